// ===== rtl/rsd_pkg.sv
// Purpose: Shared constants for the remote serial display refresher.
// Assumes: A 50 MHz system clock; the entry clock comes from the host.
// Notes:   Both ends and the testbench share these constants.
//
// Overview of operation
// - Store thirty-five bits per character plus twenty-five.
// - Host sends five column parts, 7N+5 each.
// - Each part opens with five-bit column code.
// - Separate entry clock and display clock.
// - Host holds load request low while loading.
// - Ready low first; host shifts only then.
// - Serial input gated, open only during loading.
// - Host shifts exactly total bits, code aligned.
// - Load request high returns shifting to display.
// - Refresh shifts 7N+5 bits, then displays.
// - Count shifts; timer starts on clock low.
// - Timer holds shift counter cleared and stopped.
// - Shifting starts only on a full cycle.
// - Optional on-time limit, else follow timer.
// - Storage may be a one-bit-wide addressed memory.
// - Display registers advance on falling clock edge.
// - A one bit lights its dot.
// - Display packages hold 28 bits, four characters.
// - Every column refreshed at 100 Hz or faster.

package rsd_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int N_CHARS_DEF       = 16; // Characters in the string
    localparam int STORE_PER_CHAR    = 35; // Five columns of seven dots
    localparam int STORE_EXTRA       = 25; // Five column codes of five bits
    localparam int COL_BITS_PER_CHAR = 7;  // Dots per column per character
    localparam int CODE_W            = 5;  // Column code width
    localparam int PKG_BITS          = 28; // One display package register

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_NS     = 20;        // 50 MHz system clock
    localparam int ENTRY_HALF_NS  = 80;        // Host entry clock half period
    localparam int ENTRY_HALF     = (ENTRY_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int DISP_HALF_NS   = 100;       // Display clock half period
    localparam int DISP_HALF      = (DISP_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int SHOW_NS        = 1000000;   // Display period per column
    localparam int SHOW_CYCLES    = SHOW_NS / SYS_CLK_NS;
    localparam int ON_NS          = 500000;    // Limited column on-time
    localparam int ON_CYCLES      = ON_NS / SYS_CLK_NS;

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RSD_ALIGN = 2'h0, // Wait for a full display clock cycle
        RSD_SHIFT = 2'h1, // Recirculate one column part
        RSD_SHOW  = 2'h3, // Display period running
        RSD_LOAD  = 2'h2  // Host is loading
    } rsd_dev_state_t;

    typedef enum logic [1:0] {
        RSH_IDLE  = 2'h0, // Nothing to send
        RSH_REQ   = 2'h1, // Request raised, waiting for ready
        RSH_SHIFT = 2'h3, // Bits being clocked out
        RSH_DONE  = 2'h2  // Request released
    } rsd_host_state_t;

endpackage : rsd_pkg

// ===== rtl/rsd_link_if.sv
// Purpose: Serial load link between host and display interface.
// Assumes: The host makes the entry clock; all signals are plain levels.
// Notes:   Load request and ready are active low.
`timescale 1ns/1ns

interface rsd_link_if;
    logic entry_clk;   // Data entry clock, driven by host
    logic entry_data;  // Serial data, changes while entry_clk is low
    logic load_n;      // Load request, active low
    logic ready_n;     // Device accepts data, active low

    modport dev (
        input  entry_clk,
        input  entry_data,
        input  load_n,
        output ready_n
    );

    modport host (
        output entry_clk,
        output entry_data,
        output load_n,
        input  ready_n
    );
endinterface : rsd_link_if

// ===== rtl/rsd_sync.sv
// Purpose: Two flip-flop level synchroniser.
// Assumes: Inputs are levels or toggles held for several clocks.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns

module rsd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta; // First stage, may go metastable

    // ------------------------------------------------------------
    // Two stages
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : rsd_sync

// ===== rtl/rsd_device.sv
// Purpose: Display interface: stores decoded column data and refreshes.
// Assumes: sys_clk is the display clock; link.entry_clk is the host's.
// Notes:   Storage is one recirculating loop: store, display, column code.
`timescale 1ns/1ns

module rsd_device #(
    parameter int N_CHARS     = rsd_pkg::N_CHARS_DEF, // Characters in string
    parameter int SHOW_CYCLES = rsd_pkg::SHOW_CYCLES, // Display period
    parameter int ON_CYCLES   = rsd_pkg::ON_CYCLES    // Limited on-time
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    rsd_link_if.dev                     link,
    input  wire logic                   intensity_en,
    output logic [7*N_CHARS-1:0]        dot_rows,
    output logic [rsd_pkg::CODE_W-1:0]  col_drive,
    output logic                        shift_clk,
    output logic                        loading
);

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int TOTAL     = rsd_pkg::STORE_PER_CHAR * N_CHARS
                             + rsd_pkg::STORE_EXTRA;
    localparam int DISP_W    = rsd_pkg::COL_BITS_PER_CHAR * N_CHARS;
    localparam int SHIFT_LEN = DISP_W + rsd_pkg::CODE_W;
    localparam int CW        = $clog2(SHIFT_LEN + 1);
    localparam int TW        = $clog2(SHOW_CYCLES + 1);
    localparam int DW        = $clog2(rsd_pkg::DISP_HALF + 1);

    // ------------------------------------------------------------
    // Column gate
    // ------------------------------------------------------------
    // One-hot code selects a column; nothing drives unless enabled
    function automatic logic [rsd_pkg::CODE_W-1:0] rsd_col_gate(
        input logic [rsd_pkg::CODE_W-1:0] code,
        input logic                       on
    );
        rsd_col_gate = on ? code : '0;
    endfunction : rsd_col_gate

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                       cap_bit;     // Last bit seen on entry clock
    logic                       cap_tgl;     // Toggles once per entry bit
    logic                       load_n_s;    // Synchronised load request
    logic                       tgl_s;       // Synchronised toggle
    logic                       tgl_d;       // Previous toggle, for edge
    logic                       bit_evt;     // A new entry bit is ready
    logic [TOTAL-1:0]           chain;       // Whole storage loop
    logic [DW-1:0]              dcnt;        // Display clock half counter
    logic                       dclk;        // Display shift clock phase
    logic                       dedge;       // Phase about to flip
    logic                       dfall;       // Falling display clock edge
    logic                       drise;       // Rising display clock edge
    logic [CW-1:0]              scnt;        // Shift counter
    logic [TW-1:0]              tmr;         // Display period timer count
    logic                       col_on;      // Column may be driven
    rsd_pkg::rsd_dev_state_t    state;       // Refresh sequencer
    rsd_pkg::rsd_dev_state_t    next_state;  // Next sequencer state

    // ------------------------------------------------------------
    // Entry clock domain
    // ------------------------------------------------------------
    // Capture each bit and flag it by a toggle; the bit stays put for a
    // whole entry period, far longer than the crossing takes.
    always_ff @(posedge link.entry_clk or posedge rst) begin
        if (rst) begin
            cap_bit <= 1'b0;
            cap_tgl <= 1'b0;
        end else begin
            cap_bit <= link.entry_data;
            cap_tgl <= ~cap_tgl;
        end
    end

    // ------------------------------------------------------------
    // Crossing into the display clock domain
    // ------------------------------------------------------------
    rsd_sync #(
        .W (2)
    ) u_sync (
        .clk (sys_clk),
        .rst (rst),
        .d   ({link.load_n, cap_tgl}),
        .q   ({load_n_s, tgl_s})
    );

    // Toggle edge marks one entry bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tgl_d <= 1'b0;
        end else begin
            tgl_d <= tgl_s;
        end
    end

    assign bit_evt = tgl_s ^ tgl_d;

    // ------------------------------------------------------------
    // Display clock
    // ------------------------------------------------------------
    // Free-running divider; shifting only looks at its edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dcnt <= '0;
            dclk <= 1'b1;
        end else if (dedge) begin
            dcnt <= '0;
            dclk <= ~dclk;
        end else begin
            dcnt <= dcnt + 1'b1;
        end
    end

    assign dedge = (dcnt == DW'(rsd_pkg::DISP_HALF - 1));
    assign dfall = dedge & dclk;
    assign drise = dedge & ~dclk;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            rsd_pkg::RSD_ALIGN: begin
                // Enter shifting only as a fresh full cycle begins
                if (!load_n_s) begin
                    next_state = rsd_pkg::RSD_LOAD;
                end else if (drise) begin
                    next_state = rsd_pkg::RSD_SHIFT;
                end
            end
            rsd_pkg::RSD_SHIFT: begin
                // Last of 7N+5 shifts lands on a falling edge
                if (!load_n_s) begin
                    next_state = rsd_pkg::RSD_LOAD;
                end else if (dfall && scnt == CW'(SHIFT_LEN - 1)) begin
                    next_state = rsd_pkg::RSD_SHOW;
                end
            end
            rsd_pkg::RSD_SHOW: begin
                if (!load_n_s) begin
                    next_state = rsd_pkg::RSD_LOAD;
                end else if (tmr == TW'(SHOW_CYCLES - 1)) begin
                    next_state = rsd_pkg::RSD_ALIGN;
                end
            end
            rsd_pkg::RSD_LOAD: begin
                // Release hands shifting back to the display clock
                if (load_n_s) begin
                    next_state = rsd_pkg::RSD_ALIGN;
                end
            end
            default: begin
                next_state = rsd_pkg::RSD_ALIGN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= rsd_pkg::RSD_ALIGN;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Ready toward the host
    // ------------------------------------------------------------
    // Low only once the loading state is really entered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link.ready_n <= 1'b1;
            loading      <= 1'b0;
        end else begin
            link.ready_n <= (next_state != rsd_pkg::RSD_LOAD);
            loading      <= (next_state == rsd_pkg::RSD_LOAD);
        end
    end

    // ------------------------------------------------------------
    // Shift counter
    // ------------------------------------------------------------
    // Cleared and frozen outside shifting, so the timer holds it at zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scnt <= '0;
        end else if (state != rsd_pkg::RSD_SHIFT) begin
            scnt <= '0;
        end else if (dfall) begin
            scnt <= scnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Display period timer and intensity limiter
    // ------------------------------------------------------------
    // One period per column part; five periods of 1 ms plus short
    // shifts keep each column well above 100 refreshes per second.
    always_ff @(posedge sys_clk or posedge rst) begin : display_period_timer
        if (rst) begin
            tmr <= '0;
        end else if (state == rsd_pkg::RSD_SHOW) begin
            tmr <= tmr + 1'b1;
        end else begin
            tmr <= '0;
        end
    end

    // Limiter trims on-time; disabled, the drive follows the timer
    always_comb begin : intensity_limiter
        if (intensity_en) begin
            col_on = (state == rsd_pkg::RSD_SHOW) && (tmr < TW'(ON_CYCLES));
        end else begin
            col_on = (state == rsd_pkg::RSD_SHOW);
        end
    end

    // ------------------------------------------------------------
    // Storage loop
    // ------------------------------------------------------------
    // Top CODE_W bits are the column code register, the next DISP_W the
    // display string (28 bits per package), the rest plain storage.
    // A flop loop is used instead of an addressed one-bit memory; the
    // bit order seen at the display is the same either way.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chain <= '0;
        end else if (state == rsd_pkg::RSD_LOAD && bit_evt) begin
            chain <= {chain[TOTAL-2:0], cap_bit};
        end else if (state == rsd_pkg::RSD_SHIFT && dfall) begin
            chain <= {chain[TOTAL-2:0], chain[TOTAL-1]};
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Shift clock idles high outside shifting and loading to save supply current
    always_ff @(posedge sys_clk or posedge rst) begin : clock_start_sync_ff
        if (rst) begin
            shift_clk <= 1'b1;
        end else if (next_state == rsd_pkg::RSD_SHIFT
                     || (state == rsd_pkg::RSD_SHIFT && next_state == rsd_pkg::RSD_SHOW)) begin
            // Last fall of a part must reach the pins too; its low phase is
            // cut to one cycle so column drive never meets a low clock
            shift_clk <= dedge ? ~dclk : dclk;
        end else if (state == rsd_pkg::RSD_LOAD) begin
            shift_clk <= ~bit_evt;
        end else begin
            shift_clk <= 1'b1;
        end
    end

    // Dots and column drive; drive is off whenever shifting
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dot_rows  <= '0;
            col_drive <= '0;
        end else begin
            dot_rows  <= chain[TOTAL-rsd_pkg::CODE_W-1 -: DISP_W];
            col_drive <= rsd_col_gate(chain[TOTAL-1 -: rsd_pkg::CODE_W],
                                      col_on);
        end
    end

endmodule : rsd_device

// ===== rtl/rsd_host.sv
// Purpose: Host end: streams a full load into the display interface.
// Assumes: The user supplies bits in load order with valid/ready.
// Notes:   Entry clock is divided from sys_clk and stops between bits.
`timescale 1ns/1ns

module rsd_host #(
    parameter int N_CHARS = rsd_pkg::N_CHARS_DEF // Characters in string
) (
    input  wire logic  sys_clk,
    input  wire logic  rst,
    rsd_link_if.host   link,
    input  wire logic  start,
    input  wire logic  src_bit,
    input  wire logic  src_valid,
    output logic       src_ready,
    output logic       busy,
    output logic       done
);

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int TOTAL = rsd_pkg::STORE_PER_CHAR * N_CHARS
                         + rsd_pkg::STORE_EXTRA;
    localparam int BW    = $clog2(TOTAL + 1);
    localparam int HW    = $clog2(rsd_pkg::ENTRY_HALF + 1);

    rsd_pkg::rsd_host_state_t state;   // Load sequencer
    logic                     ready_s; // Synchronised ready, active high
    logic                     ready_n_s;
    logic                     have;    // A bit sits on entry_data
    logic [HW-1:0]            hcnt;    // Half period counter
    logic [BW-1:0]            bcnt;    // Bits sent
    logic                     hend;    // Half period complete

    rsd_sync #(
        .W (1)
    ) u_sync (
        .clk (sys_clk),
        .rst (rst),
        .d   (link.ready_n),
        .q   (ready_n_s)
    );

    assign ready_s   = ~ready_n_s;
    assign hend      = (hcnt == HW'(rsd_pkg::ENTRY_HALF - 1));
    assign src_ready = (state == rsd_pkg::RSH_SHIFT) && !have;
    assign busy      = (state != rsd_pkg::RSH_IDLE);

    // ------------------------------------------------------------
    // Sequencer and bit clocking
    // ------------------------------------------------------------
    // Data is set with the clock low, raised a half period later, so the
    // device captures a settled bit on each rising entry edge.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state           <= rsd_pkg::RSH_IDLE;
            link.load_n     <= 1'b1;
            link.entry_clk  <= 1'b0;
            link.entry_data <= 1'b0;
            have            <= 1'b0;
            hcnt            <= '0;
            bcnt            <= '0;
            done            <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                rsd_pkg::RSH_IDLE: begin
                    if (start) begin
                        link.load_n <= 1'b0;
                        state       <= rsd_pkg::RSH_REQ;
                    end
                end
                rsd_pkg::RSH_REQ: begin
                    // No shifting before ready is seen low
                    if (ready_s) begin
                        state <= rsd_pkg::RSH_SHIFT;
                        bcnt  <= '0;
                    end
                end
                rsd_pkg::RSH_SHIFT: begin
                    if (!have) begin
                        if (src_valid) begin
                            link.entry_data <= src_bit;
                            have            <= 1'b1;
                            hcnt            <= '0;
                        end
                    end else if (!hend) begin
                        hcnt <= hcnt + 1'b1;
                    end else if (!link.entry_clk) begin
                        link.entry_clk <= 1'b1;
                        hcnt           <= '0;
                    end else begin
                        link.entry_clk <= 1'b0;
                        have           <= 1'b0;
                        bcnt           <= bcnt + 1'b1;
                        if (bcnt == BW'(TOTAL - 1)) begin
                            state <= rsd_pkg::RSH_DONE;
                        end
                    end
                end
                rsd_pkg::RSH_DONE: begin
                    link.load_n <= 1'b1;
                    done        <= 1'b1;
                    state       <= rsd_pkg::RSH_IDLE;
                end
                default: begin
                    state <= rsd_pkg::RSH_IDLE;
                end
            endcase
        end
    end

endmodule : rsd_host

// ===== tb/rsd_link_sva.sv
// Purpose: Concurrent checks on the load link and column drive.
// Assumes: Host entry clock is divided from sys_clk, so one domain.
// Notes:   Watches only what the two design ends drive.
`timescale 1ns/1ns

module rsd_link_sva #(
    parameter int N_CHARS = 16 // Characters in string
) (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       entry_clk,
    input wire logic       entry_data,
    input wire logic       load_n,
    input wire logic       ready_n,
    input wire logic [4:0] col_drive,
    input wire logic       shift_clk,
    input wire logic       loading
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ----------------------------
    // Shift edges since display
    // ----------------------------
    logic [15:0] n_fall; // Cleared while loading or driving
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) n_fall <= 16'h0000;
        else if (loading || col_drive != 5'h00) n_fall <= 16'h0000;
        else if ($fell(shift_clk)) n_fall <= n_fall + 16'h0001;
    end
    sequence load_start;
        load_n ##1 !load_n;
    endsequence
    // ----------------------------
    // Assertions
    // ----------------------------
    ready_answer_a: assert property (load_start |-> ##[1:6] !ready_n)
        else $error("ready did not follow load request");
    ready_drop_a: assert property ($rose(load_n) |-> ##[1:6] ready_n)
        else $error("ready held after load request released");
    ready_idle_a: assert property (load_n [*6] |-> ready_n)
        else $error("ready low without load request");
    early_clock_a: assert property (ready_n |-> !$rose(entry_clk))
        else $error("entry clock before ready");
    data_hold_a: assert property (entry_clk |-> $stable(entry_data))
        else $error("entry data moved while clock high");
    clock_high_a: assert property ($rose(entry_clk) |-> entry_clk [*4])
        else $error("entry clock high phase short");
    shift_dark_a: assert property (!shift_clk && !loading |-> col_drive == 5'h00)
        else $error("column driven while shifting");
    load_dark_a: assert property (loading ##1 loading |-> col_drive == 5'h00)
        else $error("column driven while loading");
    one_column_a: assert property (col_drive != 5'h00 |-> $onehot(col_drive))
        else $error("more than one column driven");
    shift_count_a: assert property ($rose(col_drive != 5'h00) && !loading
        |-> n_fall == 16'(7 * N_CHARS + 5))
        else $error("wrong shift count before display");
endmodule : rsd_link_sva

// ===== tb/tb_remote_serial_display_refresher.sv
// Purpose: Loads two frames and checks the refreshed columns.
// Assumes: Short display period; two characters.
// Notes:   Dot patterns are palindromes so dot order cannot mislead.
`timescale 1ns/1ns

module tb_remote_serial_display_refresher;
    localparam int NC = 2;   // Characters
    localparam int SHOW = 200; // Display period, cycles
    localparam int ON = 100; // Limited on-time, cycles
    logic            sys_clk = 1'b0;      // 50 MHz
    logic            rst = 1'b1;          // Async reset
    logic            start = 1'b0;        // Load start pulse
    logic            src_bit = 1'b0;      // Stream bit
    logic            src_valid = 1'b0;    // Stream valid
    logic            intensity_en = 1'b0; // On-time limit
    logic            src_ready, busy, done, shift_clk, loading;
    logic [7*NC-1:0] dot_rows;            // Display string
    logic [4:0]      col_drive;           // Column select
    int              n_mismatch = 0;      // Failed compares
    int              cmp_count = 0;       // All compares
    rsd_link_if link_inst ();
    rsd_device #(.N_CHARS(NC), .SHOW_CYCLES(SHOW), .ON_CYCLES(ON)) rsd_device_inst (
        .sys_clk(sys_clk), .rst(rst), .link(link_inst.dev), .intensity_en(intensity_en),
        .dot_rows(dot_rows), .col_drive(col_drive), .shift_clk(shift_clk), .loading(loading));
    rsd_host #(.N_CHARS(NC)) rsd_host_inst (.sys_clk(sys_clk), .rst(rst),
        .link(link_inst.host), .start(start), .src_bit(src_bit), .src_valid(src_valid),
        .src_ready(src_ready), .busy(busy), .done(done));
    rsd_link_sva #(.N_CHARS(NC)) rsd_link_sva_inst (.sys_clk(sys_clk), .rst(rst),
        .entry_clk(link_inst.entry_clk), .entry_data(link_inst.entry_data),
        .load_n(link_inst.load_n), .ready_n(link_inst.ready_n), .col_drive(col_drive),
        .shift_clk(shift_clk), .loading(loading));
    // Clock: invert every half period
    always #(rsd_pkg::SYS_CLK_NS / 2) sys_clk = ~sys_clk;
    // ----------------------------
    // Helpers
    // ----------------------------
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic check(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check
    // A wait that ran out ends the run
    task automatic stall();
        check(1'b0, "wait ran out");
        print_verdict();
    endtask : stall
    // Inputs move a fixed 2 ns after the edge
    task automatic tick();
        @(posedge sys_clk);
        #2;
    endtask : tick
    // Palindromic dots per column; inv gives the second frame
    function automatic logic [13:0] dots(input int k, input logic inv);
        logic [13:0] tab [5] = '{14'h3fff, 14'h0000, 14'h2001, 14'h1ffe, 14'h3003};
        return tab[k] ^ {14{inv}};
    endfunction : dots
    // Valid stays up between bits, so no double assignment in one step
    task automatic send_bit(input logic b);
        int t;
        src_bit = b;
        src_valid = 1'b1;
        for (t = 0; t < 200 && src_ready !== 1'b1; t++) tick();
        if (t == 200) stall();
        tick();
    endtask : send_bit
    // Five parts: one-hot code MSB first, then 7N dots
    task automatic load(input logic inv);
        int          t;
        logic [13:0] d;
        start = 1'b1;
        tick();
        start = 1'b0;
        check(busy === 1'b1 && link_inst.load_n === 1'b0, "load request");
        for (int k = 0; k < 5; k++) begin
            d = dots(k, inv);
            for (int i = 4; i >= 0; i--) send_bit(i == k);
            for (int i = 13; i >= 0; i--) send_bit(d[i]);
        end
        src_valid = 1'b0;
        for (t = 0; t < 100 && done !== 1'b1; t++) tick();
        if (t == 100) stall();
        check(busy === 1'b0 && link_inst.load_n === 1'b1, "load released");
    endtask : load
    // Five display periods: pairing, on-time, all columns
    task automatic watch(input logic inv, input int len);
        logic [4:0] v;
        logic [4:0] seen;
        int         t;
        seen = 5'h00;
        for (int p = 0; p < 5; p++) begin
            for (t = 0; t < 2000 && col_drive === 5'h00; t++) tick();
            if (t == 2000) stall();
            v = col_drive;
            seen = seen | v;
            for (int k = 0; k < 5; k++) begin
                if (v === 5'(1 << k)) check(dot_rows === dots(k, inv), "column dots");
            end
            for (t = 1; t < 1000 && col_drive === v; t++) tick();
            check(t >= len - 1 && t <= len + 1, "column on-time");
        end
        check(seen === 5'h1f, "five columns shown");
    endtask : watch
    // ----------------------------
    // Main sequence
    // ----------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        #2 rst = 1'b0;
        check(link_inst.ready_n === 1'b1 && link_inst.load_n === 1'b1, "idle link");
        check(col_drive === 5'h00 && shift_clk === 1'b1, "idle outputs");
        tick();
        load(1'b0);
        watch(1'b0, SHOW);
        intensity_en = 1'b1;
        load(1'b1);
        watch(1'b1, ON);
        print_verdict();
    end
endmodule : tb_remote_serial_display_refresher
